// ==== src/internal_clock_enable_and_divider.sv ====
// Purpose: clock enable, digital oscillator, loop filter and bus clock dividers
// Assumes: stop mode input comes from same-clock logic; external clock arrives on a pin
// Notes: oscillator is modelled as a half-period counter on the system clock
// Behaviour
// - bus clock quarter of osc, half generator
// - generator output feeds system integration unit
// - stop mode asserts generator stop
// - generator stop holds internal, external and base clocks low
// - internal enable equals internal-on and not stop
// - internal enable low holds internal and base clocks low
// - external enable rule; low holds external low
// - internal clock is multiple of base
// - base clock by modulo N counter
// - factor zero or one bypasses divider
// - stable base clock runs at nominal
// - period set by stage and divider fields
// - control word valid 000 through 9ff
// - comparator results feed loop filter
// - loop filter steps 1, 8 or 32
// - divider values a to f act as nine
// - stable flag when error under five percent
`timescale 1ns/1ps
module internal_clock_enable_and_divider
  import clock_gen_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic stopMode,
  input wire logic extClkPin,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [7:0] regRdata,
  output logic generatorStop,
  output logic internalGenEnable,
  output logic externalGenEnable,
  output logic internalClk,
  output logic externalClk,
  output logic baseClk,
  output logic oscOutClk,
  output logic genOutClk,
  output logic busClk,
  output logic filterStable
);

  logic rstMeta_reg;
  logic rstSyncN;
  logic extMeta_reg;
  logic extSync_reg;
  logic internalOn_reg;
  logic externalOn_reg;
  logic selExt_reg;
  logic [MULT_W-1:0] mult_reg;
  logic [WORD_W-1:0] word_reg;
  logic [WORD_W-1:0] word_next;
  logic genStop_reg;
  logic intEn_reg;
  logic extEn_reg;
  logic internal_clock_reg;
  logic external_clock_reg;
  logic [12:0] halfCnt_reg;
  logic [12:0] halfPeriod;
  logic [3:0] effDiv;
  logic wordOk;
  logic srcPrev_reg;
  logic sourceClk;
  logic [1:0] busDiv_reg;
  logic stable_reg;
  logic [7:0] rdata_reg;
  logic wordWrite;

  base_clock_if bcIf ();

  base_divider_comparator baseDiv (
    .clk(clk),
    .rstSyncN(rstSyncN),
    .bus(bcIf.divider)
  );

  // reset release through two flip-flops
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rstMeta_reg <= 1'b0;
      rstSyncN <= 1'b0;
    end
    else
    begin
      rstMeta_reg <= 1'b1;
      rstSyncN <= rstMeta_reg;
    end
  end

  // external clock pin is asynchronous to clk
  always_ff @(posedge clk or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      extMeta_reg <= 1'b0;
      extSync_reg <= 1'b0;
    end
    else
    begin
      extMeta_reg <= extClkPin;
      extSync_reg <= extMeta_reg;
    end
  end

  // control register writes
  always_ff @(posedge clk or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      internalOn_reg <= 1'b0;
      externalOn_reg <= 1'b0;
      selExt_reg <= 1'b0;
      mult_reg <= MULT_RST;
    end
    else if (regWrite)
    begin
      if (regAddr == REG_CTRL)
      begin
        internalOn_reg <= regWdata[CTRL_INT_ON];
        externalOn_reg <= regWdata[CTRL_EXT_ON];
        selExt_reg <= regWdata[CTRL_SEL_EXT];
      end
      else if (regAddr == REG_MULT)
        mult_reg <= regWdata[MULT_W-1:0];
    end
  end

  // enables are registered beside the stop flag so all three move together
  always_ff @(posedge clk or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      genStop_reg <= 1'b0;
      intEn_reg <= 1'b0;
      extEn_reg <= 1'b0;
    end
    else
    begin
      genStop_reg <= stopMode;
      intEn_reg <= internalOn_reg && !stopMode;
      extEn_reg <= externalOn_reg && !stopMode;
    end
  end

  // divider field above nine behaves as the slowest setting
  assign effDiv = (word_reg[11:8] > DIV_SLOWEST) ? DIV_SLOWEST : word_reg[11:8];
  assign halfPeriod = {1'b0, effDiv, word_reg[7:0]} + DCO_MIN_HALF;
  assign wordOk = (word_reg <= WORD_MAX);

  // oscillator: toggles each half period; a larger word runs slower
  always_ff @(posedge clk or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      halfCnt_reg <= '0;
      internal_clock_reg <= 1'b0;
    end
    else if (!intEn_reg)
    begin
      halfCnt_reg <= '0;
      internal_clock_reg <= 1'b0;
    end
    else if (halfCnt_reg + 13'h0001 >= halfPeriod)
    begin
      halfCnt_reg <= '0;
      internal_clock_reg <= ~internal_clock_reg;
    end
    else
      halfCnt_reg <= halfCnt_reg + 13'h0001;
  end

  always_ff @(posedge clk or negedge rstSyncN)
  begin
    if (!rstSyncN)
      external_clock_reg <= 1'b0;
    else
      external_clock_reg <= extEn_reg && extSync_reg;
  end

  // loop filter; 12-bit add lets a stage overflow carry into the divider field
  always_comb
  begin
    word_next = word_reg;
    if (bcIf.measValid)
    begin
      case (bcIf.measErr)
        ERR_SLOW_BIG: word_next = word_reg - STEP_BIG;
        ERR_SLOW_MID: word_next = word_reg - STEP_MID;
        ERR_SLOW_SMALL: word_next = word_reg - STEP_SMALL;
        ERR_FAST_SMALL: word_next = word_reg + STEP_SMALL;
        ERR_FAST_MID: word_next = word_reg + STEP_MID;
        ERR_FAST_BIG: word_next = word_reg + STEP_BIG;
        default: word_next = word_reg;
      endcase
    end
  end

  assign wordWrite = regWrite && (regAddr == REG_DIV || regAddr == REG_STAGE);

  // a software write to the word wins over a correction in the same cycle
  always_ff @(posedge clk or negedge rstSyncN)
  begin
    if (!rstSyncN)
      word_reg <= WORD_RST;
    else if (wordWrite && regAddr == REG_DIV)
      word_reg <= {regWdata[3:0], word_reg[7:0]};
    else if (wordWrite)
      word_reg <= {word_reg[11:8], regWdata};
    else if (intEn_reg)
      word_reg <= word_next;
  end

  always_ff @(posedge clk or negedge rstSyncN)
  begin
    if (!rstSyncN)
      stable_reg <= 1'b0;
    else
      stable_reg <= intEn_reg && bcIf.measStable;
  end

  // selected source feeds the generator output and bus clock dividers
  assign sourceClk = selExt_reg ? external_clock_reg : internal_clock_reg;

  always_ff @(posedge clk or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      srcPrev_reg <= 1'b0;
      busDiv_reg <= 2'h0;
    end
    else
    begin
      srcPrev_reg <= sourceClk;
      if (sourceClk && !srcPrev_reg)
        busDiv_reg <= busDiv_reg + 2'h1;
    end
  end

  always_ff @(posedge clk or negedge rstSyncN)
  begin
    if (!rstSyncN)
      rdata_reg <= 8'h00;
    else if (regRead)
    begin
      if (regAddr == REG_CTRL)
        rdata_reg <= {genStop_reg, wordOk, extEn_reg, intEn_reg, stable_reg, selExt_reg,
          externalOn_reg, internalOn_reg};
      else if (regAddr == REG_MULT)
        rdata_reg <= mult_reg;
      else if (regAddr == REG_DIV)
        rdata_reg <= {4'h0, word_reg[11:8]};
      else if (regAddr == REG_STAGE)
        rdata_reg <= word_reg[7:0];
      else
        rdata_reg <= 8'h00;
    end
    else
      rdata_reg <= 8'h00;
  end

  assign bcIf.genEnable = intEn_reg;
  assign bcIf.internalClk = internal_clock_reg;
  assign bcIf.multiplier = mult_reg;

  assign regRdata = rdata_reg;
  assign generatorStop = genStop_reg;
  assign internalGenEnable = intEn_reg;
  assign externalGenEnable = extEn_reg;
  assign internalClk = internal_clock_reg;
  assign externalClk = external_clock_reg;
  assign baseClk = bcIf.baseClk;
  assign oscOutClk = srcPrev_reg;
  assign genOutClk = busDiv_reg[0];
  assign busClk = busDiv_reg[1];
  assign filterStable = stable_reg;

  default clocking @(posedge clk); endclocking
  default disable iff (!rstSyncN);

  stop_follow_a: assert property (stopMode |=> generatorStop)
    else $error("generator stop not asserted in stop mode");
  stop_low_a: assert property (generatorStop |=> !internalClk && !externalClk && !baseClk)
    else $error("clocks not held low during stop");
  int_enable_a: assert property (internalGenEnable == $past(internalOn_reg && !stopMode))
    else $error("internal enable mismatch");
  int_off_a: assert property (!internalGenEnable |=> !internalClk && !baseClk)
    else $error("internal clocks not low while disabled");
  ext_off_a: assert property (!externalGenEnable |=> !externalClk)
    else $error("external clock not low while disabled");
  bus_half_a: assert property ($rose(busClk) |-> $fell(genOutClk))
    else $error("bus clock not half of generator output");
  div_clamp_a: assert property (word_reg[11:8] > DIV_SLOWEST |-> halfPeriod == 13'h09ff + DCO_MIN_HALF -
    13'h00ff + {5'h00, word_reg[7:0]})
    else $error("divider field above nine not treated as nine");
  big_step_a: assert property (bcIf.measValid && bcIf.measErr == ERR_SLOW_BIG && intEn_reg && !wordWrite
    |=> word_reg == $past(word_reg) - STEP_BIG)
    else $error("slow error did not subtract 32");
  carry_a: assert property (bcIf.measValid && bcIf.measErr == ERR_FAST_SMALL && intEn_reg && !wordWrite
    && word_reg[7:0] == 8'hff |=> word_reg[11:8] == $past(word_reg[11:8]) + 4'h1)
    else $error("stage overflow did not carry into divider");
  stable_set_a: assert property (intEn_reg && bcIf.measStable |=> filterStable)
    else $error("stable flag not set");

  lock_cov: cover property (!filterStable ##1 filterStable);
  stop_cov: cover property (internalGenEnable ##1 stopMode ##2 !internalGenEnable);
  wrap_cov: cover property (!wordOk && intEn_reg);

endmodule

// ==== src/clock_gen_pkg.sv ====
// Purpose: shared constants and types of the internal clock enable and divider block
// Assumes: system clock of 250 MHz
// Notes: register offsets are byte addresses on the plain register port
package clock_gen_pkg;

  localparam int CLK_HZ = 250_000_000;
  localparam int NOM_FREQ_HZ = 307_200;
  // nominal base clock period in system clock cycles
  localparam int NOM_PERIOD_CYC = CLK_HZ / NOM_FREQ_HZ;

  // period bounds for the frequency error bands (frequency 0.85, 0.95, 1.05, 1.15 of nominal)
  localparam int PERIOD_W = 12;
  localparam logic [PERIOD_W-1:0] SLOW_BIG_CYC = PERIOD_W'(NOM_PERIOD_CYC * 100 / 85);
  localparam logic [PERIOD_W-1:0] SLOW_MID_CYC = PERIOD_W'(NOM_PERIOD_CYC * 100 / 95);
  localparam logic [PERIOD_W-1:0] FAST_MID_CYC = PERIOD_W'(NOM_PERIOD_CYC * 100 / 105);
  localparam logic [PERIOD_W-1:0] FAST_BIG_CYC = PERIOD_W'(NOM_PERIOD_CYC * 100 / 115);
  localparam logic [PERIOD_W-1:0] NOM_CYC = PERIOD_W'(NOM_PERIOD_CYC);

  typedef enum logic [2:0] {
    ERR_SLOW_BIG = 3'b000,
    ERR_SLOW_MID = 3'b001,
    ERR_SLOW_SMALL = 3'b010,
    ERR_FAST_SMALL = 3'b011,
    ERR_FAST_MID = 3'b100,
    ERR_FAST_BIG = 3'b101
  } freq_err_e;

  localparam int MULT_W = 8;
  localparam int WORD_W = 12;
  localparam logic [WORD_W-1:0] STEP_BIG = 12'h020;
  localparam logic [WORD_W-1:0] STEP_MID = 12'h008;
  localparam logic [WORD_W-1:0] STEP_SMALL = 12'h001;
  localparam logic [WORD_W-1:0] WORD_MAX = 12'h9ff;
  localparam logic [WORD_W-1:0] WORD_RST = 12'h190;
  localparam logic [3:0] DIV_SLOWEST = 4'h9;
  localparam logic [12:0] DCO_MIN_HALF = 13'h0002;
  localparam logic [MULT_W-1:0] MULT_RST = 8'h00;

  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_MULT = 8'h04;
  localparam logic [7:0] REG_DIV = 8'h08;
  localparam logic [7:0] REG_STAGE = 8'h0c;

  localparam int CTRL_INT_ON = 0;
  localparam int CTRL_EXT_ON = 1;
  localparam int CTRL_SEL_EXT = 2;
  localparam int CTRL_STABLE = 3;
  localparam int CTRL_INT_EN = 4;
  localparam int CTRL_EXT_EN = 5;
  localparam int CTRL_WORD_OK = 6;
  localparam int CTRL_STOP = 7;

endpackage

// ==== src/base_clock_if.sv ====
// Purpose: carries the internal clock, divider control and comparator results
// Assumes: one clock domain
// Notes: ctrl side is the oscillator and loop filter, divider side the base clock logic
`timescale 1ns/1ps
interface base_clock_if;
  import clock_gen_pkg::*;
  logic genEnable;
  logic internalClk;
  logic [MULT_W-1:0] multiplier;
  logic baseClk;
  logic measValid;
  freq_err_e measErr;
  logic measStable;
  modport ctrl (output genEnable, internalClk, multiplier, input baseClk, measValid, measErr, measStable);
  modport divider (input genEnable, internalClk, multiplier, output baseClk, measValid, measErr, measStable);
endinterface

// ==== src/base_divider_comparator.sv ====
// Purpose: modulo N divider forming the base clock, and base clock frequency comparator
// Assumes: internal clock is a registered level on the system clock
// Notes: the first base period after enabling is partial and is not measured
`timescale 1ns/1ps
module base_divider_comparator
  import clock_gen_pkg::*;
(
  input wire logic clk,
  input wire logic rstSyncN,
  base_clock_if.divider bus
);

  logic iclkPrev_reg;
  logic basePrev_reg;
  logic [MULT_W-1:0] cnt_reg;
  logic baseClk_reg;
  logic [PERIOD_W-1:0] period_reg;
  logic seen_reg;
  logic measValid_reg;
  freq_err_e measErr_reg;
  logic measStable_reg;
  logic iclkRise;
  logic baseRise;
  logic bypass;

  assign iclkRise = bus.internalClk & ~iclkPrev_reg;
  assign baseRise = baseClk_reg & ~basePrev_reg;
  assign bypass = (bus.multiplier <= MULT_W'(1));
  assign bus.baseClk = baseClk_reg;
  assign bus.measValid = measValid_reg;
  assign bus.measErr = measErr_reg;
  assign bus.measStable = measStable_reg;

  function automatic freq_err_e classify(input logic [PERIOD_W-1:0] p);
    if (p > SLOW_BIG_CYC)
      return ERR_SLOW_BIG;
    else if (p > SLOW_MID_CYC)
      return ERR_SLOW_MID;
    else if (p > NOM_CYC)
      return ERR_SLOW_SMALL;
    else if (p > FAST_MID_CYC)
      return ERR_FAST_SMALL;
    else if (p > FAST_BIG_CYC)
      return ERR_FAST_MID;
    else
      return ERR_FAST_BIG;
  endfunction

  always_ff @(posedge clk or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      iclkPrev_reg <= 1'b0;
      basePrev_reg <= 1'b0;
    end
    else
    begin
      iclkPrev_reg <= bus.internalClk;
      basePrev_reg <= baseClk_reg;
    end
  end

  // modulo N counter; phase cleared while disabled so the base clock restarts cleanly
  always_ff @(posedge clk or negedge rstSyncN)
  begin
    if (!rstSyncN)
      cnt_reg <= '0;
    else if (!bus.genEnable || bypass)
      cnt_reg <= '0;
    else if (iclkRise)
      cnt_reg <= (cnt_reg + MULT_W'(1) >= bus.multiplier) ? '0 : cnt_reg + MULT_W'(1);
  end

  always_ff @(posedge clk or negedge rstSyncN)
  begin
    if (!rstSyncN)
      baseClk_reg <= 1'b0;
    else if (!bus.genEnable)
      baseClk_reg <= 1'b0;
    else if (bypass)
      baseClk_reg <= bus.internalClk;
    else
      baseClk_reg <= (cnt_reg < (bus.multiplier >> 1));
  end

  // comparator: measures base clock period against the nominal count
  always_ff @(posedge clk or negedge rstSyncN)
  begin
    if (!rstSyncN)
    begin
      period_reg <= '0;
      seen_reg <= 1'b0;
      measValid_reg <= 1'b0;
      measErr_reg <= ERR_SLOW_SMALL;
      measStable_reg <= 1'b0;
    end
    else if (!bus.genEnable)
    begin
      period_reg <= '0;
      seen_reg <= 1'b0;
      measValid_reg <= 1'b0;
      measStable_reg <= 1'b0;
    end
    else
    begin
      measValid_reg <= baseRise && seen_reg;
      if (baseRise)
      begin
        period_reg <= PERIOD_W'(1);
        seen_reg <= 1'b1;
        if (seen_reg)
        begin
          measErr_reg <= classify(period_reg);
          measStable_reg <= (period_reg <= SLOW_MID_CYC) && (period_reg > FAST_MID_CYC);
        end
      end
      else if (period_reg != '1)
        period_reg <= period_reg + PERIOD_W'(1);
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rstSyncN);

  count_range_a: assert property (!bypass |-> cnt_reg < bus.multiplier || cnt_reg == '0)
    else $error("divider count out of range");
  phase_clear_a: assert property (!bus.genEnable |=> cnt_reg == '0 && !baseClk_reg)
    else $error("divider phase not cleared while disabled");
  bypass_pass_a: assert property (bus.genEnable && bypass ##1 bus.genEnable && bypass |->
    baseClk_reg == $past(bus.internalClk))
    else $error("base clock not passing internal clock");
  divided_cov: cover property (!bypass && bus.genEnable ##1 $rose(baseClk_reg));
  measure_cov: cover property (measValid_reg && measStable_reg);

endmodule

// ==== tb/sysint_model.sv ====
// Purpose: far side model that derives bus timing from the generator outputs
// Assumes: all three clock outputs are registered levels on clk
// Notes: counts generator and oscillator rising edges inside each bus clock period
`timescale 1ns/1ps
module sysint_model
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic oscOutClk,
  input wire logic genOutClk,
  input wire logic busClk,
  output logic [7:0] genPerBus,
  output logic [7:0] oscPerBus
);
  logic oscPrev, genPrev, busPrev;
  logic [7:0] genCnt, oscCnt;
  logic genRise, oscRise;
  assign genRise = genOutClk & ~genPrev;
  assign oscRise = oscOutClk & ~oscPrev;

  // a bus period runs from one busClk rise (excluded) to the next (included)
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      {oscPrev, genPrev, busPrev} <= '0;
      {genCnt, oscCnt, genPerBus, oscPerBus} <= '0;
    end
    else
    begin
      oscPrev <= oscOutClk;
      genPrev <= genOutClk;
      busPrev <= busClk;
      if (busClk && !busPrev)
      begin
        genPerBus <= genCnt + 8'(genRise);
        oscPerBus <= oscCnt + 8'(oscRise);
        genCnt <= '0;
        oscCnt <= '0;
      end
      else
      begin
        genCnt <= genCnt + 8'(genRise);
        oscCnt <= oscCnt + 8'(oscRise);
      end
    end
  end
endmodule

// ==== tb/tb_internal_clock_enable_and_divider.sv ====
// Purpose: self-checking bench for the clock enable and divider block
// Assumes: 250 MHz clock; register port answers one cycle after a read strobe
// Notes: loop filter steps are checked on the first correction after enabling
`timescale 1ns/1ps
module tb_internal_clock_enable_and_divider
  import clock_gen_pkg::*;
;
  logic clk, rstn, stopMode, regWrite, regRead;
  logic extClkPin = 1'b0;
  logic extRun = 1'b0;
  logic [2:0] extCnt = 3'h0;
  logic [7:0] regAddr, regWdata, regRdata, genPerBus, oscPerBus, v;
  logic generatorStop, internalGenEnable, externalGenEnable, internalClk, externalClk;
  logic baseClk, oscOutClk, genOutClk, busClk, filterStable;
  logic [11:0] cur;
  logic [11:0] wTab [8] = '{12'h100, 12'h170, 12'h190, 12'h1a0, 12'h1c2, 12'h200, 12'h0f0, 12'h210};
  logic [11:0] dTab [8] = '{12'h020, 12'h008, 12'h001, 12'hfff, 12'hff8, 12'hfe0, 12'h020, 12'hfe0};
  logic sTab [8] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
  int nFail = 0;
  int nTests = 0;
  int g, k, n;
  logic h, pi, pb;

  internal_clock_enable_and_divider u_internal_clock_enable_and_divider (.clk(clk), .rstn(rstn),
    .stopMode(stopMode), .extClkPin(extClkPin), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .generatorStop(generatorStop),
    .internalGenEnable(internalGenEnable), .externalGenEnable(externalGenEnable),
    .internalClk(internalClk), .externalClk(externalClk), .baseClk(baseClk), .oscOutClk(oscOutClk),
    .genOutClk(genOutClk), .busClk(busClk), .filterStable(filterStable));

  sysint_model u_sysint_model (.clk(clk), .rstn(rstn), .oscOutClk(oscOutClk), .genOutClk(genOutClk),
    .busClk(busClk), .genPerBus(genPerBus), .oscPerBus(oscPerBus));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // external pin clock, period of 12 system cycles
  always @(posedge clk)
  begin
    extCnt <= (extCnt == 3'h5) ? 3'h0 : extCnt + 3'h1;
    if (extCnt == 3'h5 && extRun)
      extClkPin <= ~extClkPin;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp)
    begin
      nFail++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWrite <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRead <= 1'b0;
    #1 d = regRdata;
  endtask

  task automatic setWord(input logic [11:0] w);
    wr(REG_DIV, {4'h0, w[11:8]});
    wr(REG_STAGE, w[7:0]);
  endtask

  task automatic rdWord(output logic [11:0] w);
    logic [7:0] dv, st;
    rd(REG_DIV, dv);
    rd(REG_STAGE, st);
    w = {dv[3:0], st};
  endtask

  task automatic lowCheck(input logic ext);
    h = 1'b0;
    repeat (60)
    begin
      tick(1);
      h = h | internalClk | baseClk | (ext & externalClk);
    end
    chk(h, 1'b0);
  endtask

  // counts internal rising edges within one full base period
  task automatic countPer(output int c);
    k = 0;
    c = 0;
    g = 0;
    pi = internalClk;
    pb = baseClk;
    while (k < 3 && g < 9000)
    begin
      tick(1);
      g++;
      if (k == 2 && internalClk && !pi)
        c++;
      if (baseClk && !pb)
        k++;
      pi = internalClk;
      pb = baseClk;
    end
  endtask

  task automatic endSim;
    $display("checks %0d mismatches %0d", nTests, nFail);
    if (nFail == 0 && nTests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // generous bound: the whole run needs about 23000 cycles
  initial
  begin
    #(4 * 95000);
    nFail++;
    endSim;
  end

  initial
  begin
    rstn = 1'b0;
    {stopMode, regWrite, regRead} = '0;
    regAddr = 8'h00;
    regWdata = 8'h00;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    rd(REG_CTRL, v);
    chk(v[5:0], 6'h00);
    chk(v[6], 1'b1);
    rd(REG_MULT, v);
    chk(v, MULT_RST);
    rd(REG_DIV, v);
    chk(v, {4'h0, WORD_RST[11:8]});
    rd(REG_STAGE, v);
    chk(v, WORD_RST[7:0]);
    wr(8'h10, 8'hff);
    rd(8'h10, v);
    chk(v, 8'h00);
    extRun <= 1'b1;
    wr(REG_CTRL, 8'h03);
    tick(2);
    chk(internalGenEnable, 1'b1);
    chk(externalGenEnable, 1'b1);
    h = 1'b0;
    repeat (40)
    begin
      tick(1);
      h = h | externalClk;
    end
    chk(h, 1'b1);
    @(posedge clk) stopMode <= 1'b1;
    tick(1);
    chk(generatorStop, 1'b1);
    chk({internalGenEnable, externalGenEnable}, 2'b00);
    tick(3);
    lowCheck(1'b1);
    rd(REG_CTRL, v);
    chk(v[7], 1'b1);
    @(posedge clk) stopMode <= 1'b0;
    tick(3);
    chk(internalGenEnable, 1'b1);
    wr(REG_CTRL, 8'h02);
    tick(4);
    chk({internalGenEnable, externalGenEnable}, 2'b01);
    lowCheck(1'b0);
    wr(REG_CTRL, 8'h06);
    tick(400);
    chk(genPerBus, 8'd2);
    chk(oscPerBus, 8'd4);
    // bypass: base follows internal one cycle late
    for (int m = 0; m < 2; m++)
    begin
      wr(REG_CTRL, 8'h00);
      setWord(12'h020);
      wr(REG_MULT, 8'(m));
      wr(REG_CTRL, 8'h01);
      tick(4);
      h = 1'b0;
      n = 0;
      pi = internalClk;
      repeat (300)
      begin
        tick(1);
        h = h | (baseClk !== pi);
        n = n + int'(internalClk && !pi);
        pi = internalClk;
      end
      chk(h, 1'b0);
      chk(n > 0, 1'b1);
    end
    setWord(12'h063);
    for (int m = 3; m < 5; m++)
    begin
      wr(REG_MULT, 8'(m));
      countPer(n);
      chk(n, m);
    end
    tick(2500);
    chk(genPerBus, 8'd2);
    chk(oscPerBus, 8'd4);
    wr(REG_MULT, 8'h00);
    for (int i = 0; i < 8; i++)
    begin
      wr(REG_CTRL, 8'h00);
      setWord(wTab[i]);
      wr(REG_CTRL, 8'h01);
      g = 0;
      rdWord(cur);
      while (cur === wTab[i] && g < 2000)
      begin
        rdWord(cur);
        g++;
      end
      tick(3);
      chk(filterStable, sTab[i]);
      rdWord(cur);
      chk(cur, 12'(wTab[i] + dTab[i]));
    end
    wr(REG_CTRL, 8'h00);
    setWord(12'haf0);
    rd(REG_CTRL, v);
    chk(v[6], 1'b0);
    wr(REG_CTRL, 8'h01);
    g = 0;
    pi = internalClk;
    while (!(internalClk && !pi) && g < 6000)
    begin
      pi = internalClk;
      tick(1);
      g++;
    end
    n = 0;
    while (internalClk && g < 9000)
    begin
      n++;
      g++;
      tick(1);
    end
    chk(n, 2546);
    wr(REG_CTRL, 8'h00);
    endSim;
  end
endmodule
